// ### common/bmx_pkg.sv
// package: constants, encodings and tables of the byte-move execution unit
package bmx_pkg;
   // bus decode
   localparam int          BMX_ADDR_W       = 8;      // decoded low address bits
   localparam int          BMX_HTRANS_ACT   = 1;      // htrans bit set for NONSEQ/SEQ
   localparam logic        BMX_HRESP_OKAY   = 1'b0;
   // register byte offsets
   localparam logic [7:0]  BMX_OFS_INSTR    = 8'h00;
   localparam logic [7:0]  BMX_OFS_OPERAND  = 8'h04;
   localparam logic [7:0]  BMX_OFS_CONTROL  = 8'h08;
   localparam logic [7:0]  BMX_OFS_STATUS   = 8'h0c;
   localparam logic [7:0]  BMX_OFS_FLAGS    = 8'h10;
   localparam logic [7:0]  BMX_OFS_MEM_ADDR = 8'h14;
   localparam logic [7:0]  BMX_OFS_MEM_DATA = 8'h18;
   localparam logic [7:0]  BMX_OFS_GPR      = 8'h20;  // eight words up to 0x3c
   localparam logic [7:0]  BMX_GPR_MASK     = 8'he0;
   localparam int          BMX_GPR_IDX_LSB  = 2;
   // control and status bit positions
   localparam int          BMX_CTRL_START   = 0;
   localparam int          BMX_STAT_BAD     = 1;
   // condition flag bit positions
   localparam int          BMX_FLAG_N       = 3;
   localparam int          BMX_FLAG_Z       = 2;
   localparam int          BMX_FLAG_V       = 1;
   localparam logic [7:0]  BMX_FLAGS_RST    = 8'h80;  // interrupt mask set out of reset
   localparam int          BMX_BYTE_MSB     = 7;
   localparam logic [7:0]  BMX_BYTE_ZERO    = 8'h00;
   // geometry
   localparam int          BMX_NREG         = 8;
   localparam int          BMX_RIDX_W       = 3;
   localparam int          BMX_MEM_AW       = 8;
   localparam int          BMX_MEM_DEPTH    = 256;
   localparam int          BMX_CNT_W        = 3;
   localparam int          BMX_LEN_W        = 4;
   localparam logic [7:0]  BMX_ABS8_PAGE    = 8'hff;  // short absolute page
   localparam logic [15:0] BMX_PTR_STEP     = 16'h0001;
   localparam logic [BMX_CNT_W-1:0] BMX_CNT_ONE = 3'h1;
   // states per form and instruction lengths in bytes
   localparam logic [BMX_CNT_W-1:0] BMX_ST_REG  = 3'h2;
   localparam logic [BMX_CNT_W-1:0] BMX_ST_MEM  = 3'h4;
   localparam logic [BMX_CNT_W-1:0] BMX_ST_LONG = 3'h6;
   localparam logic [BMX_LEN_W-1:0] BMX_LEN_SHORT = 4'h2;
   localparam logic [BMX_LEN_W-1:0] BMX_LEN_LONG  = 4'h4;

   // addressing forms of the byte move
   typedef enum logic [3:0] {
      BMX_F_IMM      = 4'h0,
      BMX_F_REG      = 4'h1,
      BMX_F_LD_IND   = 4'h2,
      BMX_F_LD_DISP  = 4'h3,
      BMX_F_LD_INC   = 4'h4,
      BMX_F_LD_ABS8  = 4'h5,
      BMX_F_LD_ABS16 = 4'h6,
      BMX_F_ST_IND   = 4'h7,
      BMX_F_ST_DISP  = 4'h8,
      BMX_F_ST_DEC   = 4'h9,
      BMX_F_ST_ABS8  = 4'ha,
      BMX_F_ST_ABS16 = 4'hb
   } bmx_form_t;

   // instruction register layout, msb first
   typedef struct packed {
      logic                  dst_hi;
      logic [BMX_RIDX_W-1:0] dst_idx;
      logic                  src_hi;
      logic [BMX_RIDX_W-1:0] src_idx;
      logic [3:0]            form;
   } bmx_instr_t;

   // execution sequencer, one-hot
   typedef enum logic [1:0] {
      BMX_S_IDLE = 2'b01,
      BMX_S_EXEC = 2'b10
   } bmx_state_t;

   // number of states of a form
   function automatic logic [BMX_CNT_W-1:0] bmx_states(input logic [3:0] f);
      case (f)
         BMX_F_IMM, BMX_F_REG: return BMX_ST_REG;
         BMX_F_LD_IND, BMX_F_ST_IND, BMX_F_LD_ABS8, BMX_F_ST_ABS8: return BMX_ST_MEM;
         default: return BMX_ST_LONG;
      endcase
   endfunction

   // instruction length of a form
   function automatic logic [BMX_LEN_W-1:0] bmx_length(input logic [3:0] f);
      case (f)
         BMX_F_LD_DISP, BMX_F_ST_DISP, BMX_F_LD_ABS16, BMX_F_ST_ABS16: return BMX_LEN_LONG;
         default: return BMX_LEN_SHORT;
      endcase
   endfunction
endpackage

// ### dv/bmx_byte_move_checker.sv
// checker: bus and move timing of the byte-move unit
module bmx_byte_move_checker
   import bmx_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        busy,
   input wire logic        done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       wr_ph;  // write data phase running
   logic       rd_ph;  // read data phase running
   logic [7:0] ph_a;   // address of that data phase
   logic [3:0] form;   // form last written while idle
   logic       moved;  // that instruction word has run
   logic [2:0] nst;    // states expected for form
   logic [3:0] nlen;   // byte length expected for form
   wire        take = hsel & htrans[1] & hready;
   // decoded apart from the package tables so a slip there shows up
   assign nst = (form < 4'h2) ? 3'h2 :
                (form == 4'h2 || form == 4'h5 || form == 4'h7 || form == 4'ha) ? 3'h4 : 3'h6;
   assign nlen = (form == 4'h3 || form == 4'h6 || form == 4'h8 || form == 4'hb) ? 4'h4 : 4'h2;
   // track data phases and the instruction word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         rd_ph <= 1'b0;
         ph_a  <= 8'h00;
         form  <= 4'h0;
         moved <= 1'b0;
      end else begin
         wr_ph <= take & hwrite;
         rd_ph <= take & ~hwrite;
         if (take) ph_a <= haddr[7:0];
         if (wr_ph && ph_a == BMX_OFS_INSTR && !busy) begin
            form  <= hwdata[3:0];
            moved <= 1'b0;
         end else if (done) moved <= 1'b1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_write_nowait: assert property (wr_ph |-> hreadyout)
      else $error("write data phase stalled");
   chk_read_wait: assert property (rd_ph |-> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_start_busy: assert property (wr_ph && ph_a == BMX_OFS_CONTROL && hwdata[0]
      && !busy && form <= 4'hb |=> busy) else $error("move did not start");
   chk_two_states: assert property ($rose(busy) && nst == 3'h2 |-> busy[*2] ##1 !busy)
      else $error("short move length wrong");
   chk_four_states: assert property ($rose(busy) && nst == 3'h4 |-> busy[*4] ##1 !busy)
      else $error("memory move length wrong");
   chk_six_states: assert property ($rose(busy) && nst == 3'h6 |-> busy[*6] ##1 !busy)
      else $error("long move length wrong");
   chk_done_pulse: assert property ($fell(busy) |-> done ##1 !done)
      else $error("done pulse wrong");
   chk_done_idle: assert property (done |-> !busy)
      else $error("done while busy");
   chk_status_count: assert property (rd_ph && ph_a == BMX_OFS_STATUS && moved |=>
      hrdata[11:8] == nlen && hrdata[6:4] == nst) else $error("status count wrong");
   cov_long: cover property ($rose(busy) && nst == 3'h6);
   cov_short: cover property ($rose(busy) && nst == 3'h2);
   cov_status: cover property (rd_ph && ph_a == BMX_OFS_STATUS && moved);
endmodule

bind bmx_byte_move bmx_byte_move_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .busy, .done);

// ### dv/test_byte_move_instruction_exec.sv
// testbench: register-level move scenarios for the byte-move unit
module test_byte_move_instruction_exec
   import bmx_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        busy;
   logic        done;
   int          fail_count;
   int          compares;
   // single slave, so its ready is the bus ready
   bmx_byte_move dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .busy, .done);
   // 20 mhz clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for ready sampled high at a rising edge
   task automatic wait_rdy;
      int n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   // read data is taken at the edge that ends the data phase
   task automatic chkr(input logic [7:0] a, input logic [31:0] e);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      wait_rdy();
      chk(hrdata, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   function automatic logic [7:0] g(input logic [2:0] i);
      return BMX_OFS_GPR + {3'h0, i, 2'b00};
   endfunction
   task automatic setm(input logic [7:0] ma, input logic [7:0] d);
      wr(BMX_OFS_MEM_ADDR, {24'h0, ma});
      wr(BMX_OFS_MEM_DATA, {24'h0, d});
   endtask
   task automatic chkm(input logic [7:0] ma, input logic [7:0] e);
      wr(BMX_OFS_MEM_ADDR, {24'h0, ma});
      chkr(BMX_OFS_MEM_DATA, {24'h0, e});
   endtask
   // flags preset with i, h, v, c set so only n and z may follow the byte
   task automatic move(input logic [11:0] ins, input logic [15:0] opd, input logic [7:0] b,
                       input logic [2:0] st, input logic [3:0] len);
      int n = 0;
      wr(BMX_OFS_FLAGS, 32'ha3);
      wr(BMX_OFS_INSTR, {20'h0, ins});
      wr(BMX_OFS_OPERAND, {16'h0, opd});
      wr(BMX_OFS_CONTROL, 32'h1);
      do begin
         @(posedge hclk);
         n++;
      end while (done !== 1'b1 && n < 16);
      chk(n, {29'h0, st} + 32'h1);
      chkr(BMX_OFS_STATUS, {20'h0, len, 1'b0, st, 4'h0});
      chkr(BMX_OFS_FLAGS, {24'h0, 4'ha, b[7], b == 8'h00, 2'b01});
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      fail_count = 0;
      compares = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chkr(BMX_OFS_FLAGS, 32'h80);
      chkr(8'h40, 32'h0);
      setm(8'h10, 8'h5a);
      setm(8'h30, 8'hc3);
      setm(8'h77, 8'h01);
      setm(8'h34, 8'h00);
      setm(8'hab, 8'hee);
      wr(g(3'h4), 32'h0010);
      wr(g(3'h2), 32'hffff);
      wr(g(3'h0), 32'h1111);
      move({4'h1, 4'h0, BMX_F_IMM}, 16'h0080, 8'h80, 3'h2, 4'h2);
      move({4'ha, 4'h0, BMX_F_IMM}, 16'hff00, 8'h00, 3'h2, 4'h2);
      move({4'hb, 4'h1, BMX_F_REG}, 16'h0000, 8'h80, 3'h2, 4'h2);
      move({4'h6, 4'h4, BMX_F_LD_IND}, 16'h0000, 8'h5a, 3'h4, 4'h2);
      move({4'he, 4'h4, BMX_F_LD_DISP}, 16'h0020, 8'hc3, 3'h6, 4'h4);
      move({4'h7, 4'h4, BMX_F_LD_INC}, 16'h0000, 8'h5a, 3'h6, 4'h2);
      move({4'hf, 4'h0, BMX_F_LD_ABS8}, 16'h0077, 8'h01, 3'h4, 4'h2);
      move({4'h0, 4'h0, BMX_F_LD_ABS16}, 16'h1234, 8'h00, 3'h6, 4'h4);
      chkr(g(3'h1), 32'h0080);
      chkr(g(3'h2), 32'h00ff);
      chkr(g(3'h3), 32'h8000);
      chkr(g(3'h6), 32'hc35a);
      chkr(g(3'h4), 32'h0011);
      chkr(g(3'h7), 32'h015a);
      chkr(g(3'h0), 32'h1100);
      move({4'h4, 4'hb, BMX_F_ST_IND}, 16'h0000, 8'h80, 3'h4, 4'h2);
      move({4'h4, 4'he, BMX_F_ST_DISP}, 16'h0040, 8'hc3, 3'h6, 4'h4);
      move({4'h4, 4'hf, BMX_F_ST_DEC}, 16'h0000, 8'h01, 3'h6, 4'h2);
      move({4'h0, 4'h6, BMX_F_ST_ABS8}, 16'h0090, 8'h5a, 3'h4, 4'h2);
      move({4'h0, 4'h0, BMX_F_ST_ABS16}, 16'h12ab, 8'h00, 3'h6, 4'h4);
      chkm(8'h11, 8'h80);
      chkm(8'h51, 8'hc3);
      chkm(8'h10, 8'h01);
      chkr(g(3'h4), 32'h0010);
      chkm(8'h90, 8'h5a);
      chkm(8'hab, 8'h00);
      // an unknown form only raises the sticky error
      wr(BMX_OFS_INSTR, 32'hc);
      wr(BMX_OFS_CONTROL, 32'h1);
      chkr(BMX_OFS_STATUS, 32'h462);
      wr(BMX_OFS_STATUS, 32'h2);
      chkr(BMX_OFS_STATUS, 32'h460);
      stop_test();
   end
endmodule

// ### verilog/bmx_byte_move.sv
// byte-move execution unit with its ahb-lite register slave
// Functional notes
// - negative from bit 7, zero when byte zero
// - every byte move clears overflow
// - mask, half-carry, carry flags stay unchanged
// - post-increment load, pointer plus one, 6 states
// - immediate byte to register in 2 states
// - register plus 16-bit displacement, 6 states
// - absolute 8-bit 4 states, 16-bit 6 states
// - register-indirect load in 4 states
// - register to register copy in 2 states
// - register-indirect store in 4 states
// - pre-decrement store, pointer minus one, 6 states
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
module bmx_byte_move
   import bmx_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             busy,
   output logic             done
);
   // ---------------- bus slave state ----------------
   logic                  wr_pend;      // write data phase in progress
   logic                  rd_pend;      // read wait state in progress
   logic [BMX_ADDR_W-1:0] dp_addr;      // address captured in address phase

   // ---------------- software-visible state ----------------
   bmx_instr_t            instr;        // form and register selects
   logic [15:0]           operand;      // immediate, displacement or address
   logic [7:0]            condition_flags;
   logic [BMX_MEM_AW-1:0] mem_addr;     // bus window into the data memory
   logic                  bad_form;     // sticky: start with an unknown form
   logic [BMX_CNT_W-1:0]  last_states;  // states used by the last move
   logic [BMX_LEN_W-1:0]  last_len;     // length of the last move in bytes

   // ---------------- sequencer ----------------
   bmx_state_t            state;
   logic [BMX_CNT_W-1:0]  cnt;          // current state number, from one
   logic [BMX_CNT_W-1:0]  target;       // state count of the running form

   // hsize is not decoded: only whole-word single transfers are used
   wire logic unused_size = ^hsize;

   // ---------------- address phase decode ----------------
   wire logic take    = hsel && htrans[BMX_HTRANS_ACT] && hready;
   wire logic take_rd = take && !hwrite;
   wire logic idle    = (state == BMX_S_IDLE);

   // data phase register selects
   wire logic hit_instr = (dp_addr == BMX_OFS_INSTR);
   wire logic hit_oper  = (dp_addr == BMX_OFS_OPERAND);
   wire logic hit_ctrl  = (dp_addr == BMX_OFS_CONTROL);
   wire logic hit_stat  = (dp_addr == BMX_OFS_STATUS);
   wire logic hit_flags = (dp_addr == BMX_OFS_FLAGS);
   wire logic hit_maddr = (dp_addr == BMX_OFS_MEM_ADDR);
   wire logic hit_mdata = (dp_addr == BMX_OFS_MEM_DATA);
   wire logic hit_gpr   = ((dp_addr & BMX_GPR_MASK) == BMX_OFS_GPR);
   wire logic [BMX_RIDX_W-1:0] gpr_idx = dp_addr[BMX_GPR_IDX_LSB +: BMX_RIDX_W];

   // writes that would disturb a running move are dropped while busy
   wire logic wr_idle  = wr_pend && idle;
   wire logic wr_instr = wr_idle && hit_instr;
   wire logic wr_oper  = wr_idle && hit_oper;
   wire logic wr_flags = wr_idle && hit_flags;
   wire logic wr_maddr = wr_idle && hit_maddr;
   wire logic wr_mdata = wr_idle && hit_mdata;
   wire logic wr_gpr   = wr_idle && hit_gpr;
   // the error clear is honoured even while busy
   wire logic clr_bad  = wr_pend && hit_stat && hwdata[BMX_STAT_BAD];

   // ---------------- form decode ----------------
   wire logic [3:0] form  = instr.form;
   wire logic f_imm   = (form == BMX_F_IMM);
   wire logic f_disp  = (form == BMX_F_LD_DISP) || (form == BMX_F_ST_DISP);
   wire logic f_inc   = (form == BMX_F_LD_INC);
   wire logic f_dec   = (form == BMX_F_ST_DEC);
   wire logic f_abs8  = (form == BMX_F_LD_ABS8) || (form == BMX_F_ST_ABS8);
   wire logic f_abs16 = (form == BMX_F_LD_ABS16) || (form == BMX_F_ST_ABS16);
   // loads and stores each take one code range
   wire logic is_load = (form >= BMX_F_LD_IND) && (form <= BMX_F_LD_ABS16);
   wire logic is_store = (form >= BMX_F_ST_IND) && (form <= BMX_F_ST_ABS16);
   // codes above the last store form are unknown
   wire logic form_ok = (form <= BMX_F_ST_ABS16);

   // a start request launches only a known form while idle
   wire logic start_req = wr_idle && hit_ctrl && hwdata[BMX_CTRL_START];
   wire logic go        = start_req && form_ok;
   wire logic bad_set   = start_req && !form_ok;

   // ---------------- operand paths ----------------
   logic [15:0] src_word;   // source register, whole pair
   logic [15:0] dst_word;   // destination register, whole pair
   logic [15:0] gpr_rd;     // register read for the bus
   logic [7:0]  mem_rdata;  // registered memory read data

   // byte lane of the source pair
   wire logic [7:0]  src_byte = instr.src_hi ? src_word[15:8] : src_word[7:0];
   // loads point through the source, stores through the destination
   wire logic [15:0] ptr = is_store ? dst_word : src_word;
   wire logic [15:0] ea_disp = 16'(ptr + operand);
   wire logic [15:0] ea_dec  = 16'(ptr - BMX_PTR_STEP);
   wire logic [15:0] ptr_inc = 16'(ptr + BMX_PTR_STEP);
   // short absolute sits in the top page
   wire logic [15:0] ea_abs8 = {BMX_ABS8_PAGE, operand[7:0]};
   // indirect forms use the pointer as is
   wire logic [15:0] ea = f_disp  ? ea_disp :
                          f_dec   ? ea_dec  :
                          f_abs8  ? ea_abs8 :
                          f_abs16 ? operand : ptr;

   wire logic [7:0] res = is_load ? mem_rdata :
                          f_imm   ? operand[7:0] : src_byte;

   // ---------------- sequencing points ----------------
   // one state per clock, data access in the next-to-last state
   wire logic last     = !idle && (cnt == target);
   wire logic mem_slot = !idle && (is_load || is_store)
                         && (cnt == BMX_CNT_W'(target - BMX_CNT_ONE));
   wire logic exec_st  = mem_slot && is_store;

   // register file write ports
   wire logic a_we = last && !is_store;
   wire logic step = last && (f_inc || f_dec);
   wire logic b_we = step || wr_gpr;
   wire logic [BMX_RIDX_W-1:0] b_idx = !step ? gpr_idx :
                                       f_inc ? instr.src_idx : instr.dst_idx;
   wire logic [15:0] b_data = !step ? hwdata[15:0] :
                              f_inc ? ptr_inc : ea_dec;

   // memory port: the sequencer owns it while busy, the bus otherwise
   wire logic mem_we = exec_st || wr_mdata;
   wire logic [BMX_MEM_AW-1:0] mem_a = idle ? mem_addr : ea[BMX_MEM_AW-1:0];
   wire logic [7:0] mem_wd = idle ? hwdata[7:0] : src_byte;

   // ---------------- flag update ----------------
   logic [7:0] next_flags;
   always_comb begin
      next_flags = condition_flags;
      // sign and zero from the moved byte
      next_flags[BMX_FLAG_N] = res[BMX_BYTE_MSB];
      next_flags[BMX_FLAG_Z] = (res == BMX_BYTE_ZERO);
      next_flags[BMX_FLAG_V] = 1'b0;
   end

   // ---------------- read data selection ----------------
   // busy, error, states and length in one word
   wire logic [31:0] stat_word = 32'({last_len, 1'b0, last_states, 2'b00, bad_form, busy});
   // unmapped offsets read as zero
   wire logic [31:0] rd_mux = hit_gpr   ? 32'(gpr_rd)          :
                              hit_instr ? 32'(instr)           :
                              hit_oper  ? 32'(operand)         :
                              hit_stat  ? stat_word            :
                              hit_flags ? 32'(condition_flags) :
                              hit_maddr ? 32'(mem_addr)        :
                              hit_mdata ? 32'(mem_rdata)       : 32'h0000_0000;

   // ---------------- submodules ----------------
   bmx_regfile u_regs (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .a_we     (a_we),
      .a_idx    (instr.dst_idx),
      .a_hi     (instr.dst_hi),
      .a_data   (res),
      .b_we     (b_we),
      .b_idx    (b_idx),
      .b_data   (b_data),
      .rd0_idx  (instr.src_idx),
      .rd0_data (src_word),
      .rd1_idx  (instr.dst_idx),
      .rd1_data (dst_word),
      .rd2_idx  (gpr_idx),
      .rd2_data (gpr_rd)
   );

   bmx_mem u_mem (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .we      (mem_we),
      .addr    (mem_a),
      .wdata   (mem_wd),
      .rdata   (mem_rdata)
   );

   // bus phase tracking: writes finish in their data phase, reads
   // take one wait state so the memory's registered data can be used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= '0;
      end else if (ce) begin
         // each data phase flag lasts one cycle
         wr_pend <= take && hwrite;
         rd_pend <= take_rd;
         // hold the address for the data phase
         if (take) begin
            dp_addr <= haddr[BMX_ADDR_W-1:0];
         end
      end
   end

   // bus answer; response is always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
         hresp     <= BMX_HRESP_OKAY;
      end else if (ce) begin
         hresp <= BMX_HRESP_OKAY;
         if (take_rd) begin
            // stretch the read by one wait state
            hreadyout <= 1'b0;
         end else if (rd_pend) begin
            // registered data meets the ready
            hreadyout <= 1'b1;
            hrdata    <= rd_mux;
         end
      end
   end

   // software registers loaded only while no move runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr    <= '0;
         operand  <= 16'h0000;
         mem_addr <= '0;
      end else if (ce) begin
         // form and register selects
         if (wr_instr) begin
            instr <= bmx_instr_t'(hwdata[$bits(bmx_instr_t)-1:0]);
         end
         // immediate, displacement or address
         if (wr_oper) begin
            operand <= hwdata[15:0];
         end
         // window address into the memory
         if (wr_maddr) begin
            mem_addr <= hwdata[BMX_MEM_AW-1:0];
         end
      end
   end

   // condition flags: the move's update, or a software load when idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         condition_flags <= BMX_FLAGS_RST;
      end else if (ce) begin
         if (last) begin
            // the move's result owns the flags
            condition_flags <= next_flags;
         end else if (wr_flags) begin
            // software load, only while idle
            condition_flags <= hwdata[7:0];
         end
      end
   end

   // status: bad form is sticky and a new error beats the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bad_form    <= 1'b0;
         last_states <= '0;
         last_len    <= '0;
      end else if (ce) begin
         if (bad_set) begin
            // an unknown form was started
            bad_form <= 1'b1;
         end else if (clr_bad) begin
            // software writes one to clear
            bad_form <= 1'b0;
         end
         // keep the figures of the finished move
         if (last) begin
            last_states <= cnt;
            last_len    <= bmx_length(form);
         end
      end
   end

   // sequencer: counts the form's states, one per clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state  <= BMX_S_IDLE;
         cnt    <= '0;
         target <= '0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else if (ce) begin
         // done marks the cycle after the last state
         done <= last;
         unique case (state)
            // launch: the first state is the edge after the start write
            BMX_S_IDLE: begin
               // unknown forms never leave idle
               if (go) begin
                  state  <= BMX_S_EXEC;
                  cnt    <= BMX_CNT_ONE;
                  // state count from the form table
                  target <= bmx_states(form);
                  busy   <= 1'b1;
               end
            end
            // run: the last state writes back and frees the unit
            BMX_S_EXEC: begin
               if (last) begin
                  // write-back edge frees the unit
                  state <= BMX_S_IDLE;
                  busy  <= 1'b0;
               end else begin
                  // one state per clock
                  cnt <= BMX_CNT_W'(cnt + BMX_CNT_ONE);
               end
            end
            // a corrupted code falls back to idle
            default: begin
               state <= BMX_S_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ### verilog/bmx_mem.sv
// byte-wide data memory with a registered read port
module bmx_mem
   import bmx_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  ce,
   input  wire logic                  we,
   input  wire logic [BMX_MEM_AW-1:0] addr,
   input  wire logic [7:0]            wdata,
   output logic      [7:0]            rdata
);
   // storage, no reset so it maps onto ram
   logic [7:0] store [BMX_MEM_DEPTH];

   // write port
   always_ff @(posedge hclk) begin
      if (ce && we) begin
         store[addr] <= wdata;
      end
   end

   // read data always taken from the addressed byte one edge later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata <= BMX_BYTE_ZERO;
      end else if (ce) begin
         rdata <= store[addr];
      end
   end
endmodule

// ### verilog/bmx_regfile.sv
// eight 16-bit general registers, byte port a over word port b
module bmx_regfile
   import bmx_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  ce,
   input  wire logic                  a_we,
   input  wire logic [BMX_RIDX_W-1:0] a_idx,
   input  wire logic                  a_hi,
   input  wire logic [7:0]            a_data,
   input  wire logic                  b_we,
   input  wire logic [BMX_RIDX_W-1:0] b_idx,
   input  wire logic [15:0]           b_data,
   input  wire logic [BMX_RIDX_W-1:0] rd0_idx,
   output logic      [15:0]           rd0_data,
   input  wire logic [BMX_RIDX_W-1:0] rd1_idx,
   output logic      [15:0]           rd1_data,
   input  wire logic [BMX_RIDX_W-1:0] rd2_idx,
   output logic      [15:0]           rd2_data
);
   logic [15:0] gpr [BMX_NREG];   // register array

   // one register per entry; the byte port wins its lane so that a
   // load into the pointer's own half overrides the pointer step
   for (genvar i = 0; i < BMX_NREG; i++) begin : g_reg
      wire logic a_hit = a_we && (a_idx == BMX_RIDX_W'(i));
      wire logic b_hit = b_we && (b_idx == BMX_RIDX_W'(i));
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            gpr[i] <= 16'h0000;
         end else if (ce) begin
            if (a_hit && a_hi) begin
               gpr[i][15:8] <= a_data;
            end else if (b_hit) begin
               gpr[i][15:8] <= b_data[15:8];
            end
            if (a_hit && !a_hi) begin
               gpr[i][7:0] <= a_data;
            end else if (b_hit) begin
               gpr[i][7:0] <= b_data[7:0];
            end
         end
      end
   end

   // combinational read ports
   assign rd0_data = gpr[rd0_idx];
   assign rd1_data = gpr[rd1_idx];
   assign rd2_data = gpr[rd2_idx];
endmodule
